/* spstc_core.v */
// SPI side of the shared serial interface: master or slave, one byte a transfer.
// Assumes pins resolved outside from out/oe pairs; control bits come in as ports.
`include "spstc_defs.vh"

module spstc_core (
  input  wire                     i_clk,
  input  wire                     i_srst,
  input  wire                     i_serial_if_enable,
  input  wire [`SPSTC_MODE_W-1:0] i_interface_mode_field,
  input  wire                     i_select_pin_enable,
  input  wire                     i_clock_idle_polarity,
  input  wire                     i_clock_edge_select,
  input  wire                     i_tbc_tick,
  input  wire                     i_tmr_tick,
  input  wire                     i_sdr_wr_en,
  input  wire [`SPSTC_DATA_W-1:0] i_sdr_wr_data,
  input  wire                     i_transfer_done_clr,
  input  wire                     i_write_collision_clr,
  output wire [`SPSTC_DATA_W-1:0] o_shift_data_reg,
  output reg                      o_transfer_done_flag,
  output reg                      o_write_collision_flag,
  output reg                      o_busy,
  output wire                     o_rx_valid,
  output wire [`SPSTC_DATA_W-1:0] o_rx_data,
  input  wire                     i_rx_ready,
  input  wire                     i_sck,
  output reg                      o_sck,
  output reg                      o_sck_oe,
  input  wire                     i_sdi,
  output reg                      o_sdo,
  output reg                      o_sdo_oe,
  input  wire                     i_slave_select_n,
  output reg                      o_slave_select_n,
  output reg                      o_slave_select_n_oe
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  reg [1:0] sck_sy_q;
  reg [1:0] sdi_sy_q;
  reg [1:0] sel_sy_q;
  reg       sck_old_q;
  reg       sel_old_q;
  wire      sel_act;

  always @(posedge i_clk) begin
    if (i_srst) begin
      sck_sy_q  <= 2'h0;
      sdi_sy_q  <= 2'h0;
      sel_sy_q  <= 2'h3;
      sck_old_q <= 1'b0;
      sel_old_q <= 1'b0;
    end else begin
      sck_sy_q  <= {sck_sy_q[0], i_sck};
      sdi_sy_q  <= {sdi_sy_q[0], i_sdi};
      sel_sy_q  <= {sel_sy_q[0], i_slave_select_n};
      sck_old_q <= sck_sy_q[1];
      sel_old_q <= sel_act;
    end
  end

  // ------------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------------
  wire mode_slave  = (i_interface_mode_field == `SPSTC_MODE_SLAVE);
  wire mode_master = (i_interface_mode_field <= `SPSTC_MODE_MST_TMR);
  // Two-wire slave and the unused code leave the SPI engine idle
  wire run_master  = i_serial_if_enable && mode_master;
  wire run_slave   = i_serial_if_enable && mode_slave;
  wire idle_lvl    = ~i_clock_idle_polarity;
  wire lead_sample = i_clock_edge_select;
  wire sdi_s       = sdi_sy_q[1];
  // Without select pin the slave counts as always selected
  assign sel_act   = i_select_pin_enable ? ~sel_sy_q[1] : 1'b1;

  // ------------------------------------------------------------------
  // Master clock divider
  // ------------------------------------------------------------------
  reg [`SPSTC_PRE_W-1:0] pre_q;
  reg                    half_tick;

  always @(posedge i_clk) begin
    if (i_srst) begin
      pre_q <= {`SPSTC_PRE_W{1'b0}};
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  always @* begin
    case (i_interface_mode_field)
      `SPSTC_MODE_MST_D4:  half_tick = (pre_q & `SPSTC_HALF_D4) == `SPSTC_HALF_D4;
      `SPSTC_MODE_MST_D16: half_tick = (pre_q & `SPSTC_HALF_D16) == `SPSTC_HALF_D16;
      `SPSTC_MODE_MST_D64: half_tick = (pre_q & `SPSTC_HALF_D64) == `SPSTC_HALF_D64;
      `SPSTC_MODE_MST_TBC: half_tick = i_tbc_tick;
      `SPSTC_MODE_MST_TMR: half_tick = i_tmr_tick;
      default:             half_tick = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // Slave clock qualification
  // ------------------------------------------------------------------
  // The clock synchroniser resets low, so an idle-high clock would fake an edge;
  // edges count only once the clock was seen at rest in slave mode
  reg sck_arm_q;

  always @(posedge i_clk) begin
    if (i_srst) begin
      sck_arm_q <= 1'b0;
    end else begin
      sck_arm_q <= run_slave && (sck_arm_q || (sck_sy_q[1] == idle_lvl));
    end
  end

  // ------------------------------------------------------------------
  // Shift engine
  // ------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_PEND = 3'h2;
  localparam [2:0] ST_XFER = 3'h4;

  reg [2:0]               st_q;
  reg [`SPSTC_DATA_W-1:0] sr_q;
  reg [`SPSTC_EDGE_W-1:0] ecnt_q;
  reg                     rbit_q;
  wire                    fifo_ready;

  assign o_shift_data_reg = sr_q;

  wire sel_rise = sel_act && !sel_old_q;
  wire sel_fall = !sel_act && sel_old_q;
  wire m_edge   = run_master && (st_q == ST_XFER) && half_tick;
  wire s_edge   = run_slave && sel_act && sck_arm_q && (sck_sy_q[1] != sck_old_q);
  wire sh_edge  = m_edge || s_edge;
  wire is_lead  = run_master ? (o_sck == idle_lvl) : (sck_sy_q[1] != idle_lvl);
  // Master takes the pin at its trailing tick: the two-flop delay then shows
  // the leading-edge level; trailing-edge sampling is too fast for div4
  wire rx_bit   = (lead_sample && run_slave) ? rbit_q : sdi_s;
  wire [`SPSTC_DATA_W-1:0] shifted = {sr_q[`SPSTC_MSB-1:0], rx_bit};
  wire last_ev  = sh_edge && !is_lead && (ecnt_q == `SPSTC_EDGE_LAST);
  wire busy_now = (st_q == ST_XFER);
  wire wr_ok    = i_sdr_wr_en && !busy_now;

  always @(posedge i_clk) begin
    if (i_srst) begin
      st_q   <= ST_IDLE;
      sr_q   <= {`SPSTC_DATA_W{1'b0}};
      ecnt_q <= `SPSTC_EDGE_ZERO;
      rbit_q <= 1'b0;
      o_sdo  <= 1'b0;
      o_sck  <= 1'b0;
      o_busy <= 1'b0;
    end else if (!run_master && !run_slave) begin
      st_q   <= ST_IDLE;
      ecnt_q <= `SPSTC_EDGE_ZERO;
      o_busy <= 1'b0;
      o_sck  <= idle_lvl;
      if (i_sdr_wr_en) begin
        sr_q <= i_sdr_wr_data;
      end
    end else begin
      case (st_q)
        ST_IDLE: begin
          o_sck <= idle_lvl;
          if (wr_ok) begin
            sr_q  <= i_sdr_wr_data;
            o_sdo <= i_sdr_wr_data[`SPSTC_MSB];
            if (run_master) begin
              st_q <= ST_PEND;
            end
          end else if (run_slave && sel_rise) begin
            o_sdo  <= sr_q[`SPSTC_MSB];
            ecnt_q <= `SPSTC_EDGE_ZERO;
          end
          if (run_slave && s_edge) begin
            // First edge is taken here, so it counts
            st_q   <= ST_XFER;
            ecnt_q <= `SPSTC_EDGE_FIRST;
            o_busy <= 1'b1;
          end
        end
        ST_PEND: begin
          if (wr_ok) begin
            sr_q  <= i_sdr_wr_data;
            o_sdo <= i_sdr_wr_data[`SPSTC_MSB];
          end else if (fifo_ready) begin
            // Wait for room so the received byte is never dropped
            st_q   <= ST_XFER;
            ecnt_q <= `SPSTC_EDGE_ZERO;
            o_busy <= 1'b1;
          end
        end
        ST_XFER: begin
          if (run_slave && sel_fall) begin
            // Select lost mid-byte: abort, keep partial contents
            st_q   <= ST_IDLE;
            ecnt_q <= `SPSTC_EDGE_ZERO;
            o_busy <= 1'b0;
          end else if (last_ev) begin
            st_q   <= ST_IDLE;
            ecnt_q <= `SPSTC_EDGE_ZERO;
            o_busy <= 1'b0;
          end else if (sh_edge) begin
            ecnt_q <= ecnt_q + 1'b1;
          end
        end
        default: begin
          st_q   <= ST_IDLE;
          o_busy <= 1'b0;
        end
      endcase
      if (m_edge) begin
        o_sck <= ~o_sck;
      end
      if (sh_edge && is_lead) begin
        if (lead_sample) begin
          rbit_q <= sdi_s;
        end else begin
          o_sdo <= sr_q[`SPSTC_MSB];
        end
      end
      if (sh_edge && !is_lead) begin
        sr_q <= shifted;
        if (lead_sample) begin
          o_sdo <= sr_q[`SPSTC_MSB-1];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Flags; hardware set wins over a same-cycle clear
  // ------------------------------------------------------------------
  // No clock gating anywhere, so low-power idle leaves this running
  reg done_d;
  reg write_collision_flag_d;

  always @* begin
    done_d = o_transfer_done_flag && !i_transfer_done_clr;
    if (last_ev && busy_now) begin
      done_d = 1'b1;
    end
    write_collision_flag_d = o_write_collision_flag && !i_write_collision_clr;
    if (i_sdr_wr_en && busy_now) begin
      write_collision_flag_d = 1'b1;
    end
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_transfer_done_flag   <= 1'b0;
      o_write_collision_flag <= 1'b0;
    end else begin
      o_transfer_done_flag   <= done_d;
      o_write_collision_flag <= write_collision_flag_d;
    end
  end

  // ------------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_sck_oe            <= 1'b0;
      o_sdo_oe            <= 1'b0;
      o_slave_select_n    <= 1'b1;
      o_slave_select_n_oe <= 1'b0;
    end else begin
      o_sck_oe            <= run_master;
      o_sdo_oe            <= run_master || (run_slave && sel_act);
      // Select falls one cycle after the pending state is entered, ahead of the first clock edge
      o_slave_select_n    <= (st_q == ST_IDLE);
      o_slave_select_n_oe <= run_master && i_select_pin_enable;
    end
  end

  // ------------------------------------------------------------------
  // Receive buffer
  // ------------------------------------------------------------------
  // Slave cannot stall the far master; a byte ending on a full buffer is lost
  spstc_fifo #(
    .WIDTH (`SPSTC_DATA_W),
    .DEPTH (`SPSTC_FIFO_DEPTH),
    .CNT_W (`SPSTC_FIFO_CNT_W)
  ) u_rx_fifo (
    .i_clk       (i_clk),
    .i_srst      (i_srst),
    .i_in_valid  (last_ev && busy_now),
    .i_in_data   (shifted),
    .o_in_ready  (fifo_ready),
    .o_out_valid (o_rx_valid),
    .o_out_data  (o_rx_data),
    .i_out_ready (i_rx_ready)
  );

endmodule

/* spstc_core_monitor.sv */
// Port checker for the SPI serial transfer control core.
// Assumes bind onto spstc_core; one clock, sync reset.
module spstc_core_monitor (
  input wire logic       i_clk,
  input wire logic       i_srst,
  input wire logic       i_serial_if_enable,
  input wire logic [2:0] i_interface_mode_field,
  input wire logic       i_select_pin_enable,
  input wire logic       i_sdr_wr_en,
  input wire logic       i_transfer_done_clr,
  input wire logic       i_write_collision_clr,
  input wire logic       i_rx_ready,
  input wire logic       o_transfer_done_flag,
  input wire logic       o_write_collision_flag,
  input wire logic       o_busy,
  input wire logic       o_rx_valid,
  input wire logic       o_sck_oe,
  input wire logic       o_sdo_oe,
  input wire logic       o_slave_select_n_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic mst;
  assign mst = i_serial_if_enable && (i_interface_mode_field <= 3'h4);
  chk_off_float: assert property (!i_serial_if_enable |=>
    !o_sck_oe && !o_sdo_oe && !o_slave_select_n_oe) else $error("pins driven while off");
  chk_sel_unused: assert property (!i_select_pin_enable |=>
    !o_slave_select_n_oe) else $error("select driven while unused");
  chk_done_holds: assert property (o_transfer_done_flag && !i_transfer_done_clr
    |=> o_transfer_done_flag) else $error("done flag lost");
  chk_write_collision_flag_set: assert property (i_sdr_wr_en && o_busy |=>
    o_write_collision_flag) else $error("collision not flagged");
  chk_write_collision_flag_holds: assert property (o_write_collision_flag && !i_write_collision_clr
    |=> o_write_collision_flag) else $error("collision flag lost");
  chk_off_idle: assert property (!i_serial_if_enable [*2] |-> !o_busy)
    else $error("busy while off");
  chk_start_busy: assert property (i_sdr_wr_en && !o_busy && mst && !o_rx_valid
    |-> ##2 o_busy)
    else $error("write did not start");
  chk_master_clock: assert property (o_busy && mst |-> o_sck_oe)
    else $error("master clock not driven");
  cover property (o_transfer_done_flag && i_interface_mode_field == 3'h5);
  cover property ($rose(o_write_collision_flag));
  cover property (o_rx_valid && !i_rx_ready);
endmodule

bind spstc_core spstc_core_monitor i_spstc_core_monitor (
  .i_clk(i_clk), .i_srst(i_srst), .i_serial_if_enable(i_serial_if_enable),
  .i_interface_mode_field(i_interface_mode_field), .i_select_pin_enable(i_select_pin_enable),
  .i_sdr_wr_en(i_sdr_wr_en), .i_transfer_done_clr(i_transfer_done_clr),
  .i_write_collision_clr(i_write_collision_clr), .i_rx_ready(i_rx_ready),
  .o_transfer_done_flag(o_transfer_done_flag), .o_write_collision_flag(o_write_collision_flag),
  .o_busy(o_busy), .o_rx_valid(o_rx_valid), .o_sck_oe(o_sck_oe), .o_sdo_oe(o_sdo_oe),
  .o_slave_select_n_oe(o_slave_select_n_oe));

/* spstc_defs.vh */
// Constants for the SPI serial transfer control block.
// Assumes inclusion by bare name from the core and FIFO files.
// Behaviour
// - Nothing transfers until the serial interface enable input is high.
// - Master mode: writing the shift data register starts a full-duplex byte transfer.
// - Transfer done flag set by hardware on completion, held until software clears.
// - Slave mode: shift data register byte goes out on data out under master clocking.
// - Slave mode: data in bits shift into the shift data register on master clock.
// - Slave first output bit timing follows clock polarity and edge select.
// - Logic keeps working and completing transfers in the low-power idle mode.
// - Mode field: 000 to 100 master clock sources, 101 slave, 110 two-wire slave.
// - Interface disabled: data in, data out, clock and select pins float.
`ifndef SPSTC_DEFS_VH
`define SPSTC_DEFS_VH

// ------------------------------------------------------------------
// Modes
// ------------------------------------------------------------------
`define SPSTC_MODE_W        3
`define SPSTC_MODE_MST_D4   3'h0
`define SPSTC_MODE_MST_D16  3'h1
`define SPSTC_MODE_MST_D64  3'h2
`define SPSTC_MODE_MST_TBC  3'h3
`define SPSTC_MODE_MST_TMR  3'h4
`define SPSTC_MODE_SLAVE    3'h5
`define SPSTC_MODE_TWI      3'h6

// ------------------------------------------------------------------
// Clock division: half-period masks on a free counter
// ------------------------------------------------------------------
`define SPSTC_PRE_W         5
`define SPSTC_HALF_D4       5'h01
`define SPSTC_HALF_D16      5'h07
`define SPSTC_HALF_D64      5'h1F

// ------------------------------------------------------------------
// Data path
// ------------------------------------------------------------------
`define SPSTC_DATA_W        8
`define SPSTC_MSB           7
`define SPSTC_EDGE_W        4
`define SPSTC_EDGE_LAST     4'hF
`define SPSTC_EDGE_ZERO     4'h0
`define SPSTC_EDGE_FIRST    4'h1
`define SPSTC_FIFO_DEPTH    4
`define SPSTC_FIFO_CNT_W    3

`endif

/* spstc_fifo.v */
// Small flop FIFO whose head is always in slot zero.
// Assumes one clock and a synchronous active-high reset.
`include "spstc_defs.vh"

module spstc_fifo #(
  parameter WIDTH = `SPSTC_DATA_W,
  parameter DEPTH = `SPSTC_FIFO_DEPTH,
  parameter CNT_W = `SPSTC_FIFO_CNT_W
) (
  input  wire             i_clk,
  input  wire             i_srst,
  input  wire             i_in_valid,
  input  wire [WIDTH-1:0] i_in_data,
  output reg              o_in_ready,
  output reg              o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input  wire             i_out_ready
);

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  // Shifting head costs muxes but keeps the read data straight off a flop
  reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg  [CNT_W-1:0] cnt_q;
  reg  [CNT_W-1:0] cnt_d;
  wire             push = i_in_valid && o_in_ready;
  wire             pop  = o_out_valid && i_out_ready;
  integer          i;

  assign o_out_data = mem_q[0];

  always @* begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      cnt_q       <= {CNT_W{1'b0}};
      o_in_ready  <= 1'b1;
      o_out_valid <= 1'b0;
    end else begin
      cnt_q       <= cnt_d;
      o_in_ready  <= (cnt_d != DEPTH[CNT_W-1:0]);
      o_out_valid <= (cnt_d != {CNT_W{1'b0}});
    end
  end

  always @(posedge i_clk) begin
    for (i = 0; i < DEPTH; i = i + 1) begin
      if (pop) begin
        if (push && (i == cnt_q - 1)) begin
          mem_q[i] <= i_in_data;
        end else if (i < DEPTH - 1) begin
          mem_q[i] <= mem_q[i+1];
        end
      end else if (push && (i == cnt_q)) begin
        mem_q[i] <= i_in_data;
      end
    end
  end

endmodule

/* spstc_peer.sv */
// External SPI master model, one byte a frame, MSB first.
// Assumes idle-low clock, sampling on the leading edge.
module spstc_peer (
  output logic o_sck,
  output logic o_sel_n,
  output logic o_sdi,
  input  wire logic i_sdo
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock stands still between frames
  initial begin
    o_sck = 1'b0;
    o_sel_n = 1'b1;
    o_sdi = 1'b0;
  end
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
    o_sel_n = 1'b0;
    #125;
    for (int i = 7; i >= 0; i--) begin
      o_sdi = tx[i];
      #62.5 o_sck = 1'b1;
      rx[i] = i_sdo;
      #62.5 o_sck = 1'b0;
    end
    #125 o_sel_n = 1'b1;
    // Released line shows the inverse, never a stale bit
    o_sdi = ~o_sdi;
  endtask
endmodule

/* test_spstc_core.sv */
// Self-checking bench for the SPI serial transfer control core.
// Assumes spstc_peer as far master; master mode loops data out to in.
`include "spstc_defs.vh"
module test_spstc_core;
  timeunit 1ns;
  timeprecision 100ps;
  logic       i_clk, i_srst, en, sel_en, wr, dclr, wclr, rdy, tbc, tmr, pol, edg;
  logic [2:0] mode;
  logic [7:0] wdat, sdr, rxd, got;
  logic       done, write_collision_flag, busy, rxv, sck, sck_oe, sdo, sdo_oe, ss, ss_oe;
  logic       p_sck, p_sel, p_sdi;
  logic [1:0] tick_q;
  int         miscompares, compares;
  typedef struct {logic [2:0] mode; logic [7:0] data;} spstc_row_t;
  spstc_row_t rows [5] = '{'{3'h0, 8'hA5}, '{3'h1, 8'h5A}, '{3'h2, 8'hC3},
                           '{3'h3, 8'h81}, '{3'h4, 8'h7E}};
  spstc_core i_spstc_core (.i_clk(i_clk), .i_srst(i_srst), .i_serial_if_enable(en),
    .i_interface_mode_field(mode), .i_select_pin_enable(sel_en),
    .i_clock_idle_polarity(pol), .i_clock_edge_select(edg), .i_tbc_tick(tbc),
    .i_tmr_tick(tmr), .i_sdr_wr_en(wr), .i_sdr_wr_data(wdat), .i_transfer_done_clr(dclr),
    .i_write_collision_clr(wclr), .o_shift_data_reg(sdr), .o_transfer_done_flag(done),
    .o_write_collision_flag(write_collision_flag), .o_busy(busy), .o_rx_valid(rxv), .o_rx_data(rxd),
    .i_rx_ready(rdy), .i_sck(sck_oe ? sck : p_sck), .o_sck(sck), .o_sck_oe(sck_oe),
    .i_sdi(mode == 3'h5 ? p_sdi : sdo), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
    .i_slave_select_n(ss_oe ? ss : p_sel), .o_slave_select_n(ss),
    .o_slave_select_n_oe(ss_oe));
  spstc_peer i_spstc_peer (.o_sck(p_sck), .o_sel_n(p_sel), .o_sdi(p_sdi),
    .i_sdo(sdo_oe ? sdo : ~sdo));
  // ----------------------------------------------------------------
  // Clock, ticks, watchdog
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    #1 tick_q = tick_q + 2'h1;
    tbc = (tick_q == 2'h0);
    tmr = (tick_q == 2'h2);
  end
  initial begin
    #300000;
    miscompares++;
    complete_run;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic write(input logic [7:0] d);
    step(1);
    wr = 1'b1;
    wdat = d;
    step(1);
    wr = 1'b0;
  endtask
  task automatic wait_done;
    int n;
    for (n = 0; n < 3000 && done !== 1'b1; n++) step(1);
    chk({7'h0, done}, 8'h01);
    dclr = 1'b1;
    step(1);
    dclr = 1'b0;
    step(1);
  endtask
  task automatic pop(input logic [7:0] exp);
    int n;
    for (n = 0; n < 50 && rxv !== 1'b1; n++) step(1);
    chk(rxd, exp);
    rdy = 1'b1;
    step(1);
    rdy = 1'b0;
  endtask
  task automatic complete_run;
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {i_srst, en, sel_en, wr, dclr, wclr, rdy, tbc, tmr} = 9'h100;
    {mode, wdat, tick_q} = 13'h0;
    {pol, edg} = 2'h3;
    step(3);
    i_srst = 1'b0;
    chk({done, write_collision_flag, busy, rxv, sck_oe, sdo_oe, ss_oe, ss}, 8'h01);
    // Disabled: write only loads, nothing moves
    write(8'h33);
    step(40);
    chk({3'h0, done, busy, sck_oe, sdo_oe, ss_oe}, 8'h00);
    chk(sdr, 8'h33);
    en = 1'b1;
    sel_en = 1'b1;
    foreach (rows[r]) begin
      mode = rows[r].mode;
      write(rows[r].data);
      wait_done;
      chk(sdr, rows[r].data);
      chk({7'h0, done}, 8'h00);
      pop(rows[r].data);
    end
    // Collision mid-transfer, select pin unused
    mode = 3'h0;
    sel_en = 1'b0;
    write(8'h96);
    step(6);
    write(8'h11);
    wait_done;
    chk({6'h0, write_collision_flag, ss_oe}, 8'h02);
    pop(8'h96);
    wclr = 1'b1;
    step(1);
    wclr = 1'b0;
    // Slave: five frames fill the four-word buffer, last byte dropped
    mode = 3'h5;
    sel_en = 1'b1;
    for (int k = 0; k < 5; k++) begin
      write(8'hA0 + k[7:0]);
      i_spstc_peer.frame(8'h31 + k[7:0], got);
      chk(got, 8'hA0 + k[7:0]);
      wait_done;
    end
    for (int k = 0; k < 4; k++) pop(8'h31 + k[7:0]);
    step(2);
    chk({7'h0, rxv}, 8'h00);
    // Two-wire code leaves the SPI engine idle; the write only loads
    mode = 3'h6;
    write(8'h5C);
    step(40);
    chk({3'h0, done, busy, sck_oe, sdo_oe, ss_oe}, 8'h00);
    chk(sdr, 8'h5C);
    // Idle-high clock, sampling on the trailing edge, div16 master
    {mode, pol, edg} = 5'h04;
    step(2);
    chk({7'h0, sck}, 8'h01);
    write(8'h3C);
    wait_done;
    chk(sdr, 8'h3C);
    pop(8'h3C);
    // Reset in mid-transfer clears state and nothing restarts
    write(8'hE7);
    step(20);
    i_srst = 1'b1;
    step(1);
    i_srst = 1'b0;
    chk({done, write_collision_flag, busy, rxv, sck_oe, sdo_oe, ss_oe, ss}, 8'h01);
    chk(sdr, 8'h00);
    step(40);
    chk({7'h0, busy}, 8'h00);
    complete_run;
  end
endmodule
